// *** simd_cc_pkg.sv ***
// simd_cc_pkg: shared types and constants for the compare/convert/integer datapath
// assumes: a single core clock domain and synchronous reset
package simd_cc_pkg;

  // ***************************************************
  // control/status and conversion constants
  // ***************************************************
  localparam logic [31:0] CSR_RESET = 32'h0000_1f80;
  localparam int RC_LSB = 13;
  localparam logic [1:0] RC_NEAR = 2'h0;
  localparam logic [1:0] RC_DOWN = 2'h1;
  localparam logic [1:0] RC_UP = 2'h2;
  localparam logic [1:0] RC_ZERO = 2'h3;
  localparam logic [31:0] INT_INDEF = 32'h8000_0000;
  localparam logic [7:0] SP_BIAS = 8'h7f;
  localparam logic [7:0] F2I_POINT = 8'h96;
  localparam logic [7:0] F2I_LIMIT = 8'h9e;
  localparam logic [7:0] SHIFT_CAP = 8'h37;

  // ***************************************************
  // operation codes
  // ***************************************************
  typedef enum logic [4:0] {
    OP_CMPP = 5'h00, OP_CMPS = 5'h01, OP_COMI = 5'h02, OP_UCOMI = 5'h03,
    OP_SHUF = 5'h04, OP_UNPH = 5'h05, OP_UNPL = 5'h06, OP_PI2F = 5'h07,
    OP_SI2F = 5'h08, OP_PF2I = 5'h09, OP_PF2IT = 5'h0a, OP_SF2I = 5'h0b,
    OP_SF2IT = 5'h0c, OP_AVGB = 5'h0d, OP_AVGW = 5'h0e, OP_WEXT = 5'h0f,
    OP_WINS = 5'h10, OP_MAXUB = 5'h11, OP_MINUB = 5'h12, OP_MAXSW = 5'h13,
    OP_MINSW = 5'h14, OP_BMASK = 5'h15, OP_MULHU = 5'h16, OP_SAD = 5'h17,
    OP_WSHUF = 5'h18, OP_CSLD = 5'h19, OP_CSST = 5'h1a
  } op_t;

  // ***************************************************
  // carriers
  // ***************************************************
  typedef struct packed {
    logic valid;
    op_t op;
    logic [7:0] imm;
    logic wide;
    logic [127:0] dst;
    logic [127:0] src;
    logic [31:0] gpr;
  } req_t;

  typedef struct packed {
    logic zf;
    logic pf;
    logic cf;
  } flags_t;

  typedef struct packed {
    logic valid;
    logic [127:0] vec;
    logic [31:0] gpr;
    flags_t flags;
    logic inv;
  } res_t;

  typedef struct packed {
    res_t res;
    logic [31:0] csr;
  } st_t;

endpackage

// *** simd_cc_unit.sv ***
// simd_cc_unit: one-cycle compare, shuffle, convert and 64-bit integer datapath
// assumes: issue logic presents one request per cycle, results read one cycle later
//
// What this block does
// [RL1] packed compare gives all-ones or all-zeros 32-bit element per predicate
// [RL2] immediate picks one of eight compare conditions
// [RL3] scalar compare tests lowest elements, mask into low doubleword
// [RL4] flag compares report result only through zero, parity, carry flags
// [RL5] ordered compare invalid on any NaN, unordered only on signaling NaN
// [RL6] shuffle: two low results from destination, two high from source
// [RL7] high unpack interleaves upper elements of destination and source
// [RL8] low unpack interleaves lower elements of destination and source
// [RL9] packed int-to-float converts two doublewords, rounding by status mode
// [RL10] scalar int-to-float converts one doubleword, rounding by status mode
// [RL11] packed float-to-int gives two doublewords, rounding by status mode
// [RL12] scalar float-to-int gives one doubleword, rounding by status mode
// [RL13] truncating conversions always round toward zero
// [RL14] averages add elements, add one, shift right one bit
// [RL15] word extract copies selected word out; insert writes word in
// [RL16] unsigned byte max and min keep greater or lesser byte
// [RL17] signed word max and min keep greater or lesser word
// [RL18] byte mask gathers byte top bits: 8 bits, or 16 when wide
// [RL19] unsigned high multiply keeps upper word of each product
// [RL20] sum of absolute byte differences lands in low word
// [RL21] word shuffle reorders source words by 8-bit selector
// [RL22] status load replaces register; status store returns its contents
// [RL23] predicate codes 0..7: eq, lt, le, unord, neq, nlt, nle, ord
// [RL24] unordered sets all three flags, greater none, less carry, equal zero
// [RL25] shuffle selector uses two bits per element, lowest pair first
// [RL26] unpack results alternate destination then source, lowest first
`timescale 1ns/10ps
module simd_cc_unit
  import simd_cc_pkg::*;
(
  input logic CLK,
  input logic SRST,
  input req_t REQ,
  output res_t RES,
  output logic [31:0] CSR
);

  // ***************************************************
  // helper functions
  // ***************************************************
  function automatic logic [31:0] el(input logic [127:0] v, input logic [1:0] i);
    return v[{i, 5'h00} +: 32];
  endfunction

  function automatic logic is_nan(input logic [31:0] a);
    return (&a[30:23]) & (|a[22:0]);
  endfunction

  function automatic logic is_snan(input logic [31:0] a);
    return is_nan(a) & ~a[22];
  endfunction

  // returns {unordered, less, equal}
  function automatic logic [2:0] rel(input logic [31:0] a, input logic [31:0] b);
    logic un;
    logic eq;
    logic lt;
    un = is_nan(a) | is_nan(b);
    eq = ~un & ((a[30:0] == 31'h0 && b[30:0] == 31'h0) || a == b);
    if (a[31] != b[31]) lt = a[31];
    else if (a[31]) lt = a[30:0] > b[30:0];
    else lt = a[30:0] < b[30:0];
    return {un, ~un & ~eq & lt, eq};
  endfunction

  function automatic logic pred(input logic [31:0] a, input logic [31:0] b, input logic [2:0] p);
    logic [2:0] r;
    logic base;
    r = rel(a, b);
    case (p[1:0]) // [RL2] [RL23]
      2'h0: base = r[0];
      2'h1: base = r[1];
      2'h2: base = r[1] | r[0];
      default: base = r[2];
    endcase
    return base ^ p[2];
  endfunction

  function automatic logic rnd(input logic [1:0] rc, input logic s, input logic lsb,
                               input logic g, input logic st);
    case (rc)
      RC_NEAR: return g & (st | lsb);
      RC_DOWN: return s & (g | st);
      RC_UP: return ~s & (g | st);
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] i2f(input logic [31:0] x, input logic [1:0] rc);
    logic [31:0] m;
    logic [31:0] n;
    logic [4:0] p;
    logic [24:0] sig;
    logic [7:0] e;
    m = x[31] ? 32'h0 - x : x;
    p = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) p = 5'(i);
    end
    n = m << (5'h1f - p);
    sig = {2'h1, n[30:8]} + 25'(rnd(rc, x[31], n[8], n[7], |n[6:0]));
    e = SP_BIAS + {3'h0, p} + {7'h00, sig[24]};
    if (m == 32'h0) return 32'h0;
    return {x[31], e, sig[24] ? sig[23:1] : sig[22:0]};
  endfunction

  // returns {invalid, integer}
  function automatic logic [32:0] f2i(input logic [31:0] f, input logic [1:0] rc);
    logic [7:0] e;
    logic [7:0] sh;
    logic [55:0] x;
    logic [32:0] mag;
    logic [32:0] lim;
    e = f[30:23];
    if (e >= F2I_POINT) sh = 8'h00;
    else if (F2I_POINT - e > SHIFT_CAP) sh = SHIFT_CAP;
    else sh = F2I_POINT - e;
    x = {|e, f[22:0], 32'h0} >> sh;
    if (e >= F2I_POINT) mag = {9'h000, |e, f[22:0]} << (e - F2I_POINT);
    else mag = {9'h000, x[55:32]} + 33'(rnd(rc, f[31], x[32], x[31], |x[30:0]));
    lim = f[31] ? {1'b0, INT_INDEF} : {1'b0, INT_INDEF - 32'h1};
    if (e >= F2I_LIMIT || mag > lim) return {1'b1, INT_INDEF};
    return {1'b0, f[31] ? 32'h0 - mag[31:0] : mag[31:0]};
  endfunction

  // ***************************************************
  // next-state logic
  // ***************************************************
  st_t st_r;
  st_t st_nxt;

  always_comb begin
    logic [127:0] d;
    logic [127:0] s;
    logic [63:0] v;
    logic [32:0] cv0;
    logic [32:0] cv1;
    logic [2:0] rl;
    logic [1:0] rc;
    logic [31:0] prod;
    logic [15:0] sad;
    logic [7:0] ab;
    logic [7:0] bb;
    d = REQ.dst;
    s = REQ.src;
    v = 64'h0;
    rl = rel(d[31:0], s[31:0]);
    rc = (REQ.op == OP_PF2IT || REQ.op == OP_SF2IT) ? RC_ZERO : st_r.csr[RC_LSB +: 2]; // [RL13]
    cv0 = f2i(s[31:0], rc);
    cv1 = f2i(s[63:32], rc);
    prod = 32'h0;
    sad = 16'h0;
    ab = 8'h00;
    bb = 8'h00;
    st_nxt = st_r;
    st_nxt.res.valid = 1'b0;
    st_nxt.res.inv = 1'b0;
    if (REQ.valid) begin
      st_nxt.res.valid = 1'b1;
      st_nxt.res.vec = d;
      st_nxt.res.gpr = 32'h0;
      case (REQ.op)
        OP_CMPP: begin
          for (int i = 0; i < 4; i++) begin
            st_nxt.res.vec[i*32 +: 32] = {32{pred(el(d, 2'(i)), el(s, 2'(i)), REQ.imm[2:0])}}; // [RL1]
          end
        end
        OP_CMPS: st_nxt.res.vec[31:0] = {32{pred(d[31:0], s[31:0], REQ.imm[2:0])}}; // [RL3]
        OP_COMI, OP_UCOMI: begin
          st_nxt.res.flags = rl[2] ? 3'h7 : {rl[0], 1'b0, rl[1]}; // [RL4] [RL24]
          if (REQ.op == OP_COMI) st_nxt.res.inv = rl[2]; // [RL5]
          else st_nxt.res.inv = is_snan(d[31:0]) | is_snan(s[31:0]); // [RL5]
        end
        OP_SHUF: st_nxt.res.vec = {el(s, REQ.imm[7:6]), el(s, REQ.imm[5:4]),
                                   el(d, REQ.imm[3:2]), el(d, REQ.imm[1:0])}; // [RL6] [RL25]
        OP_UNPH: st_nxt.res.vec = {s[127:96], d[127:96], s[95:64], d[95:64]}; // [RL7] [RL26]
        OP_UNPL: st_nxt.res.vec = {s[63:32], d[63:32], s[31:0], d[31:0]}; // [RL8] [RL26]
        OP_PI2F: st_nxt.res.vec[63:0] = {i2f(s[63:32], rc), i2f(s[31:0], rc)}; // [RL9]
        OP_SI2F: st_nxt.res.vec[31:0] = i2f(REQ.gpr, rc); // [RL10]
        OP_PF2I, OP_PF2IT: begin
          st_nxt.res.vec = {64'h0, cv1[31:0], cv0[31:0]}; // [RL11] [RL13]
          st_nxt.res.inv = cv0[32] | cv1[32];
        end
        OP_SF2I, OP_SF2IT: begin
          st_nxt.res.gpr = cv0[31:0]; // [RL12] [RL13]
          st_nxt.res.inv = cv0[32];
        end
        OP_AVGB: begin
          for (int i = 0; i < 8; i++) begin
            v[i*8 +: 8] = 8'(({1'b0, d[i*8 +: 8]} + {1'b0, s[i*8 +: 8]} + 9'h001) >> 1); // [RL14]
          end
        end
        OP_AVGW: begin
          for (int i = 0; i < 4; i++) begin
            v[i*16 +: 16] = 16'(({1'b0, d[i*16 +: 16]} + {1'b0, s[i*16 +: 16]} + 17'h00001) >> 1); // [RL14]
          end
        end
        OP_WEXT: st_nxt.res.gpr = {16'h0, d[{REQ.imm[1:0], 4'h0} +: 16]}; // [RL15]
        OP_WINS: st_nxt.res.vec[{REQ.imm[1:0], 4'h0} +: 16] = REQ.gpr[15:0]; // [RL15]
        OP_MAXUB, OP_MINUB: begin
          for (int i = 0; i < 8; i++) begin
            ab = d[i*8 +: 8];
            bb = s[i*8 +: 8];
            v[i*8 +: 8] = ((ab > bb) == (REQ.op == OP_MAXUB)) ? ab : bb; // [RL16]
          end
        end
        OP_MAXSW, OP_MINSW: begin
          for (int i = 0; i < 4; i++) begin
            v[i*16 +: 16] = (($signed(d[i*16 +: 16]) > $signed(s[i*16 +: 16])) == (REQ.op == OP_MAXSW))
                            ? d[i*16 +: 16] : s[i*16 +: 16]; // [RL17]
          end
        end
        OP_BMASK: begin
          for (int i = 0; i < 16; i++) begin
            if (i < 8 || REQ.wide) st_nxt.res.gpr[i] = d[i*8 + 7]; // [RL18]
          end
        end
        OP_MULHU: begin
          for (int i = 0; i < 4; i++) begin
            prod = d[i*16 +: 16] * s[i*16 +: 16];
            v[i*16 +: 16] = prod[31:16]; // [RL19]
          end
        end
        OP_SAD: begin
          for (int i = 0; i < 8; i++) begin
            ab = d[i*8 +: 8];
            bb = s[i*8 +: 8];
            sad = sad + {8'h00, (ab > bb) ? ab - bb : bb - ab}; // [RL20]
          end
          v[15:0] = sad;
        end
        OP_WSHUF: begin
          for (int i = 0; i < 4; i++) begin
            v[i*16 +: 16] = s[{REQ.imm[i*2 +: 2], 4'h0} +: 16]; // [RL21]
          end
        end
        OP_CSLD: st_nxt.csr = REQ.gpr; // [RL22]
        OP_CSST: st_nxt.res.gpr = st_r.csr; // [RL22]
        default: begin
          st_nxt.res = st_r.res;
          st_nxt.res.valid = 1'b0;
          st_nxt.res.inv = 1'b0;
        end
      endcase
      if (REQ.op inside {OP_AVGB, OP_AVGW, OP_MAXUB, OP_MINUB, OP_MAXSW,
                         OP_MINSW, OP_MULHU, OP_SAD, OP_WSHUF}) begin
        st_nxt.res.vec = {64'h0, v};
      end
    end
  end

  // ***************************************************
  // state register
  // ***************************************************
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_r <= '0;
      st_r.csr <= CSR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RES = st_r.res;
  assign CSR = st_r.csr;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  pcmp_mask_a: assert property ( // [RL1]
    $past(REQ.valid) && $past(REQ.op) == OP_CMPP |->
      (RES.vec[31:0] == 32'h0 || RES.vec[31:0] == 32'hffff_ffff) &&
      (RES.vec[127:96] == 32'h0 || RES.vec[127:96] == 32'hffff_ffff))
    else $error("packed compare element not a full mask");

  ord_pred_a: assert property ( // [RL2]
    REQ.valid && REQ.op == OP_CMPS && REQ.imm[2:0] == 3'h7 &&
    !is_nan(REQ.dst[31:0]) && !is_nan(REQ.src[31:0]) ##1 1'b1 |->
      RES.vec[31:0] == 32'hffff_ffff)
    else $error("ordered predicate false on ordered operands");

  unord_flags_a: assert property ( // [RL24]
    REQ.valid && REQ.op inside {OP_COMI, OP_UCOMI} && (is_nan(REQ.dst[31:0]) || is_nan(REQ.src[31:0])) |=>
      RES.flags == 3'h7 && RES.valid)
    else $error("unordered compare did not set all flags");

  quiet_nan_a: assert property ( // [RL5]
    REQ.valid && REQ.op == OP_UCOMI && is_nan(REQ.dst[31:0]) && REQ.dst[22] &&
    !is_snan(REQ.src[31:0]) |=> !RES.inv)
    else $error("unordered compare raised invalid on quiet NaN");

  shuf_low_a: assert property ( // [RL6]
    $past(REQ.valid) && $past(REQ.op) == OP_SHUF |->
      RES.vec[31:0] == el($past(REQ.dst), $past(REQ.imm[1:0])))
    else $error("shuffle low element wrong");

  unpl_order_a: assert property ( // [RL8]
    $past(REQ.valid) && $past(REQ.op) == OP_UNPL |->
      RES.vec[63:32] == $past(REQ.src[31:0]))
    else $error("low unpack order wrong");

  avgb_round_a: assert property ( // [RL14]
    $past(REQ.valid) && $past(REQ.op) == OP_AVGB |->
      {1'b0, RES.vec[7:0]} == 9'(({1'b0, $past(REQ.dst[7:0])} + {1'b0, $past(REQ.src[7:0])} + 9'h001) >> 1))
    else $error("byte average wrong");

  bmask_bits_a: assert property ( // [RL18]
    $past(REQ.valid) && $past(REQ.op) == OP_BMASK |->
      RES.gpr[0] == $past(REQ.dst[7]) && (RES.gpr[15:8] == 8'h00 || $past(REQ.wide)))
    else $error("byte mask wrong");

  csr_load_a: assert property ( // [RL22]
    REQ.valid && REQ.op == OP_CSLD ##1 !(REQ.valid && REQ.op == OP_CSLD) |->
      CSR == $past(REQ.gpr) ##1 CSR == $past(REQ.gpr, 2))
    else $error("status load value not held");

  trunc_zero_a: assert property ( // [RL13]
    REQ.valid && REQ.op == OP_SF2IT && REQ.src[31:0] == 32'hc020_0000 |=>
      RES.gpr == 32'hffff_fffe)
    else $error("truncating conversion did not round toward zero");

endmodule // simd_cc_unit

// *** simd_cc_issue_model.sv ***
// simd_cc_issue_model: issue and decode side that feeds the datapath requests
// assumes: simd_cc_pkg compiled first; one clock, requests changed at the falling edge
`timescale 1ns/10ps
module simd_cc_issue_model
  import simd_cc_pkg::*;
(
  input wire logic clk,
  output req_t req
);
  initial req = '0;

  // ***************************************************
  // one request, held across exactly one taking edge
  // ***************************************************
  task automatic send(input op_t op, input logic [7:0] imm, input logic wide,
                      input logic [127:0] dst, input logic [127:0] src, input logic [31:0] gpr);
    @(negedge clk);
    req.op = op;
    req.imm = imm;
    req.wide = wide;
    req.dst = dst;
    req.src = src;
    req.gpr = gpr;
    req.valid = 1'b1;
    @(negedge clk);
    req.valid = 1'b0;
    // released operands toggle so a stale value never passes for live data
    req.dst = ~req.dst;
    req.src = ~req.src;
    req.gpr = ~req.gpr;
    req.imm = ~req.imm;
  endtask
endmodule // simd_cc_issue_model

// *** simd_compare_convert_int_datapath_tb.sv ***
// simd_compare_convert_int_datapath_tb: self-checking bench for simd_cc_unit
// assumes: simd_cc_pkg and simd_cc_issue_model compiled first; 10 MHz clock
`timescale 1ns/10ps
module simd_compare_convert_int_datapath_tb
  import simd_cc_pkg::*;
;
  localparam logic [31:0] F1 = 32'h3f80_0000;
  localparam logic [31:0] F2 = 32'h4000_0000;
  localparam logic [31:0] QN = 32'h7fc0_0000;
  localparam logic [31:0] SN = 32'h7fa0_0000;
  logic clk;
  logic srst;
  req_t req;
  res_t res;
  logic [31:0] csr;
  int errors;
  int checked;

  simd_cc_unit uut (.CLK(clk), .SRST(srst), .REQ(req), .RES(res), .CSR(csr));
  simd_cc_issue_model drv (.clk(clk), .req(req));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ***************************************************
  // shared helpers
  // ***************************************************
  task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
    checked++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask

  task automatic issue(input op_t op, input logic [7:0] imm, input logic wide,
                       input logic [127:0] d, input logic [127:0] s, input logic [31:0] g);
    drv.send(op, imm, wide, d, s, g);
    chk("res_valid", 1'b1, res.valid);
  endtask

  task automatic summarize();
    $display("counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic hit(int p, int r);
    case (p)
      0: return r == 0;
      1: return r == 1;
      2: return r <= 1;
      3: return r == 3;
      4: return r != 0;
      5: return r != 1;
      6: return r >= 2;
      default: return r != 3;
    endcase
  endfunction

  function automatic logic [63:0] iref(op_t op, logic [63:0] d, logic [63:0] s);
    logic [63:0] r;
    logic [16:0] t;
    logic [31:0] p;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      t = 17'(d[8*i+:8]) + 17'(s[8*i+:8]) + 17'h1;
      if (op == OP_AVGB) r[8*i+:8] = t[8:1];
      if (op == OP_MAXUB) r[8*i+:8] = (d[8*i+:8] > s[8*i+:8]) ? d[8*i+:8] : s[8*i+:8];
      if (op == OP_MINUB) r[8*i+:8] = (d[8*i+:8] < s[8*i+:8]) ? d[8*i+:8] : s[8*i+:8];
      if (op == OP_SAD) r[15:0] += 16'((d[8*i+:8] > s[8*i+:8]) ? d[8*i+:8] - s[8*i+:8] : s[8*i+:8] - d[8*i+:8]);
    end
    for (int i = 0; i < 4; i++) begin
      t = 17'(d[16*i+:16]) + 17'(s[16*i+:16]) + 17'h1;
      p = 32'(d[16*i+:16]) * 32'(s[16*i+:16]);
      if (op == OP_AVGW) r[16*i+:16] = t[16:1];
      if (op == OP_MAXSW) r[16*i+:16] = ($signed(d[16*i+:16]) > $signed(s[16*i+:16])) ? d[16*i+:16] : s[16*i+:16];
      if (op == OP_MINSW) r[16*i+:16] = ($signed(d[16*i+:16]) < $signed(s[16*i+:16])) ? d[16*i+:16] : s[16*i+:16];
      if (op == OP_MULHU) r[16*i+:16] = p[31:16];
    end
    return r;
  endfunction

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset();
    chk("csr_reset", CSR_RESET, csr);
    chk("vec_reset", '0, res.vec);
    drv.send(op_t'(5'h1f), 8'h0, 1'b0, '1, '1, '1);
    chk("refused", 1'b0, res.valid);
    chk("refused_vec", '0, res.vec);
    chk("refused_gpr", '0, res.gpr);
    $display("test reset done");
  endtask

  task automatic t_rerst();
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    chk("csr_rerst", CSR_RESET, csr);
    chk("flags_rerst", '0, res.flags);
    chk("valid_rerst", 1'b0, res.valid);
    $display("test mid-run reset done");
  endtask

  task automatic t_cmp();
    logic [127:0] d;
    logic [127:0] s;
    logic [127:0] e;
    d = {QN, F2, F1, F1};
    s = {F1, F1, F2, F1};
    for (int p = 0; p < 8; p++) begin
      for (int k = 0; k < 4; k++) e[32*k+:32] = {32{hit(p, k)}};
      issue(OP_CMPP, 8'(p), 1'b0, d, s, '0);
      chk("packed_cmp", e, res.vec);
      issue(OP_CMPS, 8'(p), 1'b0, d, {s[127:32], F2}, '0);
      chk("scalar_cmp", {d[127:32], {32{hit(p, 1)}}}, res.vec);
    end
    $display("test compare done");
  endtask

  task automatic t_flags();
    logic [31:0] a[5] = '{F2, F1, F1, QN, SN};
    logic [31:0] b[5] = '{F1, F2, F1, F1, F1};
    logic [2:0] f[5] = '{3'h0, 3'h1, 3'h4, 3'h7, 3'h7};
    for (int u = 0; u < 2; u++) begin
      for (int i = 0; i < 5; i++) begin
        issue(u ? OP_UCOMI : OP_COMI, 8'h0, 1'b0, {96'h0, a[i]}, {96'h0, b[i]}, '0);
        chk("flags", f[i], res.flags);
        chk("invalid", (i == 4) || (i == 3 && u == 0), res.inv);
      end
    end
    $display("test flags done");
  endtask

  task automatic t_shuf();
    logic [127:0] d;
    logic [127:0] s;
    d = 128'hd3d3_d3d3_d2d2_d2d2_d1d1_d1d1_d0d0_d0d0;
    s = 128'h5353_5353_5252_5252_5151_5151_5050_5050;
    issue(OP_SHUF, 8'h1b, 1'b0, d, s, '0);
    chk("shuffle", {s[31:0], s[63:32], d[95:64], d[127:96]}, res.vec);
    issue(OP_UNPL, 8'h0, 1'b0, d, s, '0);
    chk("unpack_low", {s[63:32], d[63:32], s[31:0], d[31:0]}, res.vec);
    issue(OP_UNPH, 8'h0, 1'b0, d, s, '0);
    chk("unpack_high", {s[127:96], d[127:96], s[95:64], d[95:64]}, res.vec);
    issue(OP_WSHUF, 8'h1b, 1'b0, d, 128'h0123_4567_89ab_cdef, '0);
    chk("word_shuffle", 128'hcdef_89ab_4567_0123, res.vec);
    $display("test shuffle done");
  endtask

  task automatic t_conv();
    logic [31:0] pos[4] = '{32'h2, 32'h2, 32'h3, 32'h2};
    logic [31:0] neg[4] = '{32'hffff_fffe, 32'hffff_fffd, 32'hffff_fffe, 32'hffff_fffe};
    logic [31:0] flt[4] = '{32'h4b80_0000, 32'h4b80_0000, 32'h4b80_0001, 32'h4b80_0000};
    logic [127:0] d;
    logic [31:0] cv;
    d = {4{32'h5a5a_0f0f}};
    for (int r = 0; r < 4; r++) begin
      cv = CSR_RESET | (32'(r) << RC_LSB);
      issue(OP_CSLD, 8'h0, 1'b0, d, d, cv);
      chk("csr_load", cv, csr);
      issue(OP_CSST, 8'h0, 1'b0, d, d, '0);
      chk("csr_store", cv, res.gpr);
      issue(OP_SI2F, 8'h0, 1'b0, d, d, 32'h0100_0001);
      chk("si2f", {d[127:32], flt[r]}, res.vec);
      issue(OP_PI2F, 8'h0, 1'b0, d, {64'h0, 32'h0100_0001, 32'hffff_ffff}, '0);
      chk("pi2f", {d[127:64], flt[r], 32'hbf80_0000}, res.vec);
      issue(OP_SF2I, 8'h0, 1'b0, d, {96'h0, 32'hc020_0000}, '0);
      chk("sf2i", neg[r], res.gpr);
      issue(OP_PF2I, 8'h0, 1'b0, d, {64'h0, 32'h4020_0000, 32'hc020_0000}, '0);
      chk("pf2i", {64'h0, pos[r], neg[r]}, res.vec);
      issue(OP_PF2IT, 8'h0, 1'b0, d, {64'h0, 32'h4020_0000, 32'hc020_0000}, '0);
      chk("pf2i_trunc", {64'h0, 32'h2, 32'hffff_fffe}, res.vec);
      issue(OP_SF2IT, 8'h0, 1'b0, d, {96'h0, 32'hc020_0000}, '0);
      chk("sf2i_trunc", 32'hffff_fffe, res.gpr);
    end
    $display("test convert done");
  endtask

  task automatic t_int();
    op_t ops[8] = '{OP_AVGB, OP_AVGW, OP_MAXUB, OP_MINUB, OP_MAXSW, OP_MINSW, OP_MULHU, OP_SAD};
    logic [127:0] d;
    logic [127:0] s;
    logic [31:0] m;
    d = 128'h1234_5678_9abc_def0_80ff_0102_7fff_0010;
    s = 128'hfedc_ba98_7654_3210_7f01_0304_8001_00f0;
    foreach (ops[i]) begin
      issue(ops[i], 8'h0, 1'b0, d, s, '0);
      chk("int_op", {64'h0, iref(ops[i], d[63:0], s[63:0])}, res.vec);
    end
    issue(OP_WEXT, 8'h2, 1'b0, d, s, '0);
    chk("word_extract", {16'h0, d[47:32]}, res.gpr);
    issue(OP_WINS, 8'h1, 1'b0, d, s, 32'h0000_abcd);
    chk("word_insert", {d[127:32], 16'habcd, d[15:0]}, res.vec);
    for (int w = 0; w < 2; w++) begin
      m = '0;
      for (int k = 0; k < 8 + 8 * w; k++) m[k] = d[8*k+7];
      issue(OP_BMASK, 8'h0, w[0], d, s, '0);
      chk("byte_mask", m, res.gpr);
    end
    $display("test integer done");
  endtask

  // ***************************************************
  // sequence and watchdog
  // ***************************************************
  initial begin
    errors = 0;
    checked = 0;
    srst = 1'b1;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_cmp();
    t_flags();
    t_shuf();
    t_conv();
    t_rerst();
    t_int();
    summarize();
  end

  initial begin
    #300000;
    errors++;
    summarize();
  end
endmodule // simd_compare_convert_int_datapath_tb
